/* File: common/spp_params.svh */
// register map, field positions, reset values and counts of the serial port core
`ifndef SPP_PARAMS_SVH
`define SPP_PARAMS_SVH

`define SPP_CTRL_OFFSET      12'h000
`define SPP_BAUD_OFFSET      12'h004
`define SPP_STATUS_OFFSET    12'h008
`define SPP_DATA_OFFSET      12'h00c

`define SPP_CTRL_WIDTH       7
`define SPP_CTRL_RESET       7'h00
`define SPP_BAUD_WIDTH       7
`define SPP_BAUD_RESET       7'h00

`define SPP_CTRL_ENABLE_BIT  0
`define SPP_CTRL_MASTER_BIT  1
`define SPP_CTRL_LSB_BIT     2
`define SPP_CTRL_SWPC_BIT    3
`define SPP_CTRL_SWOE_BIT    4
`define SPP_CTRL_MFE_BIT     5
`define SPP_CTRL_SOE_BIT     6

`define SPP_BAUD_RATE_LSB    0
`define SPP_BAUD_RATE_MSB    2
`define SPP_BAUD_PRE_LSB     4
`define SPP_BAUD_PRE_MSB     6

`define SPP_STAT_RXFULL_BIT  0
`define SPP_STAT_TXEMPTY_BIT 1
`define SPP_STAT_BUSY_BIT    2

`define SPP_BYTE_RESET       8'h00
`define SPP_LAST_BIT         4'h7
`define SPP_BYTE_DONE        4'h8
`define SPP_LAST_RISE        4'he
`define SPP_LAST_FALL        4'hf
`define SPP_EDGE_RESET       4'h0

`endif

/* File: common/spp_pkg.sv */
// types shared by the serial port core
package spp_pkg;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_MASTER = 2'b01,
		ST_SLAVE  = 2'b10
	} xfer_state_t;

	typedef struct packed {
		logic [6:0]  ctrl;
		logic [6:0]  baud;
		logic [7:0]  tx_buf;
		logic        tx_full;
		logic [7:0]  rx_buf;
		logic        rx_full;
		logic [7:0]  shifter;
		logic        in_bit;
		logic [3:0]  edge_cnt;
		xfer_state_t state;
		logic        sck_prev;
		logic        sck_level;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        sck_out;
		logic        sck_oe;
		logic        mosi_out;
		logic        mosi_oe;
		logic        miso_out;
		logic        miso_oe;
		logic        sel_out;
		logic        sel_oe;
	} core_state_t;

endpackage

/* File: design/bit_rate_divider.sv */
// two-stage bit-rate divider producing half-bit enable pulses
`timescale 1ns/1ns
module bit_rate_divider (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,
	input  wire logic [2:0] prescale_field,
	input  wire logic [2:0] rate_select_field,
	output logic            half_tick
);

	typedef struct packed {
		logic [2:0] pre_cnt;
		logic [6:0] rate_cnt;
		logic       tick;
	} div_state_t;

	div_state_t div_reg;
	div_state_t div_next;
	logic [7:0] rate_span;
	logic [6:0] rate_limit;

	// half period is (prescale+1) * 2^rate bus clocks, so a full bit is twice that
	always_comb begin
		rate_span  = 8'h01 << rate_select_field;
		rate_limit = 7'(rate_span - 8'h01);
		div_next   = div_reg;
		div_next.tick = 1'b0;
		if (!run) begin
			div_next.pre_cnt  = 3'h0;
			div_next.rate_cnt = 7'h00;
		end else if (div_reg.pre_cnt == prescale_field) begin // [R10]
			div_next.pre_cnt = 3'h0;
			if (div_reg.rate_cnt == rate_limit) begin // [R11]
				div_next.rate_cnt = 7'h00;
				div_next.tick     = 1'b1; // [R22]
			end else begin
				div_next.rate_cnt = div_reg.rate_cnt + 7'h01;
			end
		end else begin
			div_next.pre_cnt = div_reg.pre_cnt + 3'h1;
		end
	end

	// the bus clock is the only source of this divider
	always_ff @(posedge pclk or negedge presetn) begin // [R9]
		if (!presetn) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end

	assign half_tick = div_reg.tick;

endmodule

/* File: design/pin_sync.sv */
// two-flop synchroniser bank for the serial pins
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_t;

	sync_state_t sync_reg;
	sync_state_t sync_next;

	// the first stage feeds only the second stage
	always_comb begin
		sync_next = sync_reg;
		for (int i = 0; i < WIDTH; i++) begin
			sync_next.first[i]  = async_in[i];
			sync_next.second[i] = sync_reg.first[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg.second;

endmodule

/* File: design/serial_peripheral_port_core.sv */
// serial peripheral port core with apb register access and pin routing
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "spp_params.svh"

// How it works
// [R1] only a master starts a transfer; a slave waits for select and clock
// [R2] each transfer shifts out and shifts in at once, swapping shifter contents
// [R3] the master drives the serial clock; the slave receives it as input
// [R4] a slave takes part only while its select input is low
// [R5] a written byte waits in the transmit buffer until the next transfer starts
// [R6] a completed byte moves into the receive buffer for data register reads
// [R7] master: clock out, shifter to master-out, shifter from master-in
// [R8] slave: clock from pin, shifter to master-in, shifter from master-out
// [R9] the bit-rate divider runs only from the bus clock
// [R10] prescale field divides bus clock by its code plus one
// [R11] rate field divides prescaler output by two to the power code plus one
// [R12] module disabled releases all four pins, driving none
// [R13] two-wire mode: master-out carries master data out, master-in master data in
// [R14] single-wire master uses master-out as data pin, releases master-in
// [R15] single-wire slave uses master-in as data pin, releases master-out
// [R16] single-wire direction bit: 0 input, 1 output from shifter
// [R17] shifting order is either msb first or lsb first
// [R18] master select bit 0 gives slave, 1 gives master
// [R19] disabling aborts transfers, empties buffers, clears receive-full, sets transmit-empty
// [R20] master select pin: released, mode-fault input, or automatic select output; the core has no mode-fault detection, the pin is only released or driven
// [R21] lsb-first bit 0 sends msb first, 1 sends lsb first
// [R22] bit period is bus period times prescale divisor times rate divisor
module serial_peripheral_port_core
	import spp_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        serial_clock_pin_in,
	output logic             serial_clock_pin_out,
	output logic             serial_clock_pin_oe,
	input  wire logic        mosi_pin_in,
	output logic             mosi_pin_out,
	output logic             mosi_pin_oe,
	input  wire logic        miso_pin_in,
	output logic             miso_pin_out,
	output logic             miso_pin_oe,
	input  wire logic        select_pin_in,
	output logic             select_pin_out,
	output logic             select_pin_oe
);

	core_state_t core_reg;
	core_state_t core_next;

	logic [3:0] pins_sync;
	logic       sck_s;
	logic       mosi_s;
	logic       miso_s;
	logic       sel_s;
	logic       half_tick;

	logic       module_enable;
	logic       master_select;
	logic       lsb_first_enable;
	logic       single_wire_pin_control;
	logic       single_wire_output_enable;
	logic       mode_fault_enable;
	logic       select_output_enable;

	logic       setup_phase;
	logic       access_done;
	logic       addr_ok;
	logic       data_in;
	logic       out_bit;
	logic [7:0] final_byte;
	logic [7:0] shifted;
	logic       sck_rise;
	logic       sck_fall;
	logic       selected;

	// every pin comes from outside the pclk domain, so it crosses two flops before any logic reads it
	pin_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_in({select_pin_in, miso_pin_in, mosi_pin_in, serial_clock_pin_in}),
		.sync_out(pins_sync)
	);

	assign sck_s  = pins_sync[0];
	assign mosi_s = pins_sync[1];
	assign miso_s = pins_sync[2];
	assign sel_s  = pins_sync[3];

	// the divider only runs during a master transfer, so each byte starts from a fresh count
	bit_rate_divider u_bit_rate_divider (
		.pclk             (pclk),
		.presetn          (presetn),
		.run              (core_reg.state == ST_MASTER),
		.prescale_field   (core_reg.baud[`SPP_BAUD_PRE_MSB:`SPP_BAUD_PRE_LSB]),
		.rate_select_field(core_reg.baud[`SPP_BAUD_RATE_MSB:`SPP_BAUD_RATE_LSB]),
		.half_tick        (half_tick)
	);

	assign module_enable             = core_reg.ctrl[`SPP_CTRL_ENABLE_BIT];
	assign master_select             = core_reg.ctrl[`SPP_CTRL_MASTER_BIT];
	assign lsb_first_enable          = core_reg.ctrl[`SPP_CTRL_LSB_BIT];
	assign single_wire_pin_control   = core_reg.ctrl[`SPP_CTRL_SWPC_BIT];
	assign single_wire_output_enable = core_reg.ctrl[`SPP_CTRL_SWOE_BIT];
	assign mode_fault_enable         = core_reg.ctrl[`SPP_CTRL_MFE_BIT];
	assign select_output_enable      = core_reg.ctrl[`SPP_CTRL_SOE_BIT];

	always_comb begin
		core_next   = core_reg;
		setup_phase = psel && !penable;
		access_done = psel && penable && core_reg.pready;
		addr_ok     = (paddr == `SPP_CTRL_OFFSET) || (paddr == `SPP_BAUD_OFFSET) ||
		              (paddr == `SPP_STATUS_OFFSET) || (paddr == `SPP_DATA_OFFSET);
		sck_rise    = sck_s && !core_reg.sck_prev;
		sck_fall    = !sck_s && core_reg.sck_prev;
		selected    = !sel_s; // [R4]

		// data source depends on role and single-wire choice, bit order on the lsb-first bit
		if (master_select) begin // [R18]
			data_in = single_wire_pin_control ? mosi_s : miso_s; // [R7] [R14]
		end else begin
			data_in = single_wire_pin_control ? miso_s : mosi_s; // [R8] [R15]
		end
		out_bit    = lsb_first_enable ? core_reg.shifter[0] : core_reg.shifter[7]; // [R17] [R21]
		shifted    = lsb_first_enable ? {core_reg.in_bit, core_reg.shifter[7:1]} :
		                                {core_reg.shifter[6:0], core_reg.in_bit};
		final_byte = lsb_first_enable ? {data_in, core_reg.shifter[7:1]} :
		                                {core_reg.shifter[6:0], data_in};

		core_next.sck_prev = sck_s;

		// zero-wait apb: answer in the first access cycle, data captured at setup
		core_next.pready  = setup_phase;
		core_next.pslverr = setup_phase && !addr_ok;
		if (setup_phase) begin
			core_next.prdata = 32'h0000_0000;
			if (paddr == `SPP_CTRL_OFFSET) begin
				core_next.prdata[`SPP_CTRL_WIDTH-1:0] = core_reg.ctrl;
			end else if (paddr == `SPP_BAUD_OFFSET) begin
				core_next.prdata[`SPP_BAUD_WIDTH-1:0] = core_reg.baud;
			end else if (paddr == `SPP_STATUS_OFFSET) begin
				core_next.prdata[`SPP_STAT_RXFULL_BIT]  = core_reg.rx_full;
				core_next.prdata[`SPP_STAT_TXEMPTY_BIT] = !core_reg.tx_full;
				core_next.prdata[`SPP_STAT_BUSY_BIT]    = core_reg.state != ST_IDLE;
			end else if (paddr == `SPP_DATA_OFFSET) begin
				core_next.prdata[7:0] = core_reg.rx_buf; // [R6]
			end
		end

		if (access_done && pwrite) begin
			if (paddr == `SPP_CTRL_OFFSET) begin
				core_next.ctrl = pwdata[`SPP_CTRL_WIDTH-1:0];
			end
			if (paddr == `SPP_BAUD_OFFSET) begin
				core_next.baud = pwdata[`SPP_BAUD_WIDTH-1:0];
			end
		end
		// reading the data register empties the receive buffer; a new byte below still wins
		if (access_done && !pwrite && paddr == `SPP_DATA_OFFSET) begin
			core_next.rx_full = 1'b0;
		end

		unique case (core_reg.state)
			ST_IDLE: begin
				core_next.edge_cnt  = `SPP_EDGE_RESET;
				core_next.sck_level = 1'b0;
				if (module_enable && master_select && core_reg.tx_full) begin // [R1]
					core_next.shifter = core_reg.tx_buf; // [R5]
					core_next.tx_full = 1'b0;
					core_next.state   = ST_MASTER;
				end else if (module_enable && !master_select && selected) begin // [R4]
					if (core_reg.tx_full) begin
						core_next.shifter = core_reg.tx_buf; // [R5]
						core_next.tx_full = 1'b0;
					end
					core_next.state = ST_SLAVE;
				end
			end
			ST_MASTER: begin
				if (half_tick) begin
					core_next.edge_cnt = core_reg.edge_cnt + 4'h1;
					if (!core_reg.edge_cnt[0]) begin
						core_next.sck_level = 1'b1; // [R3]
						core_next.in_bit    = data_in; // [R2]
						if (core_reg.edge_cnt == `SPP_LAST_RISE) begin
							core_next.rx_buf  = final_byte; // [R6]
							core_next.rx_full = 1'b1;
						end
					end else begin
						core_next.sck_level = 1'b0;
						if (core_reg.edge_cnt == `SPP_LAST_FALL) begin
							core_next.state = ST_IDLE;
						end else begin
							core_next.shifter = shifted; // [R2]
						end
					end
				end
			end
			ST_SLAVE: begin
				// deselect mid-byte aborts; the slave never moves the clock itself
				if (!selected) begin // [R4]
					core_next.state = ST_IDLE;
				end else if (sck_rise) begin // [R8]
					core_next.in_bit   = data_in;
					core_next.edge_cnt = core_reg.edge_cnt + 4'h1;
					if (core_reg.edge_cnt == `SPP_LAST_BIT) begin
						core_next.rx_buf  = final_byte; // [R6]
						core_next.rx_full = 1'b1;
					end
				end else if (sck_fall) begin
					if (core_reg.edge_cnt == `SPP_BYTE_DONE) begin
						core_next.edge_cnt = `SPP_EDGE_RESET;
						if (core_reg.tx_full) begin
							core_next.shifter = core_reg.tx_buf; // [R5]
							core_next.tx_full = 1'b0;
						end
					end else begin
						core_next.shifter = shifted; // [R2]
					end
				end
			end
			default: begin
				core_next.state = ST_IDLE;
			end
		endcase

		// a write lands after a load in the same cycle, so the new byte waits for the next transfer
		if (access_done && pwrite && paddr == `SPP_DATA_OFFSET && module_enable) begin
			core_next.tx_buf  = pwdata[7:0]; // [R5]
			core_next.tx_full = 1'b1;
		end

		if (!core_next.ctrl[`SPP_CTRL_ENABLE_BIT]) begin // [R19]
			core_next.state     = ST_IDLE;
			core_next.tx_buf    = `SPP_BYTE_RESET;
			core_next.rx_buf    = `SPP_BYTE_RESET;
			core_next.shifter   = `SPP_BYTE_RESET;
			core_next.tx_full   = 1'b0;
			core_next.rx_full   = 1'b0;
			core_next.edge_cnt  = `SPP_EDGE_RESET;
			core_next.sck_level = 1'b0;
		end

		// pin routing; the slave drives its data pin only while selected to avoid bus fights
		core_next.sck_out  = core_reg.sck_level;
		core_next.sck_oe   = module_enable && master_select; // [R3] [R7] [R12]
		core_next.mosi_out = out_bit;
		core_next.miso_out = out_bit;
		if (master_select) begin
			core_next.mosi_oe = module_enable &&
			                    (!single_wire_pin_control || single_wire_output_enable); // [R13] [R14] [R16]
			core_next.miso_oe = 1'b0; // [R13] [R14]
		end else begin
			core_next.mosi_oe = 1'b0; // [R13] [R15]
			core_next.miso_oe = module_enable && selected &&
			                    (!single_wire_pin_control || single_wire_output_enable); // [R8] [R15] [R16]
		end
		core_next.sel_oe  = module_enable && master_select && mode_fault_enable && select_output_enable; // [R20]
		core_next.sel_out = core_reg.state != ST_MASTER; // [R20]
		if (!module_enable) begin // [R12]
			core_next.sck_oe  = 1'b0;
			core_next.mosi_oe = 1'b0;
			core_next.miso_oe = 1'b0;
			core_next.sel_oe  = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reg         <= '0;
			core_reg.ctrl    <= `SPP_CTRL_RESET;
			core_reg.baud    <= `SPP_BAUD_RESET;
			core_reg.state   <= ST_IDLE;
			core_reg.sel_out <= 1'b1;
		end else begin
			core_reg <= core_next;
		end
	end

	assign prdata               = core_reg.prdata;
	assign pready               = core_reg.pready;
	assign pslverr              = core_reg.pslverr;
	assign serial_clock_pin_out = core_reg.sck_out;
	assign serial_clock_pin_oe  = core_reg.sck_oe;
	assign mosi_pin_out         = core_reg.mosi_out;
	assign mosi_pin_oe          = core_reg.mosi_oe;
	assign miso_pin_out         = core_reg.miso_out;
	assign miso_pin_oe          = core_reg.miso_oe;
	assign select_pin_out       = core_reg.sel_out;
	assign select_pin_oe        = core_reg.sel_oe;

endmodule

/* File: tb/serial_peripheral_port_core_test.sv */
// self-checking bench for the serial port core
`timescale 1ns/1ns
`include "spp_params.svh"
module serial_peripheral_port_core_test;
	logic        pclk, presetn, psel, penable, pwrite, bad;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, sel_o, sel_oe, m_miso;
	logic [7:0]  reply, got, sb;
	logic        ext_sck, ext_mosi, ext_sel;
	int          err_count, n_compared, n;
	wire sck_w = sck_oe ? sck_o : ext_sck;
	wire mosi_w = mosi_oe ? mosi_o : ext_mosi;
	wire miso_w = miso_oe ? miso_o : m_miso;
	wire sel_w = sel_oe ? sel_o : ext_sel;
	serial_peripheral_port_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o), .serial_clock_pin_oe(sck_oe),
		.mosi_pin_in(mosi_w), .mosi_pin_out(mosi_o), .mosi_pin_oe(mosi_oe), .miso_pin_in(miso_w),
		.miso_pin_out(miso_o), .miso_pin_oe(miso_oe), .select_pin_in(sel_w), .select_pin_out(sel_o),
		.select_pin_oe(sel_oe));
	spp_slave_model u_far (.sck(sck_w), .sel_n(sel_w), .mosi(mosi_w), .reply(reply), .miso(m_miso), .got(got));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task tick;
		@(posedge pclk);
		#1;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		logic ok;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		// answer is read settled mid-cycle; the request is released only after the edge that takes it
		do begin
			@(negedge pclk);
			ok = pready;
			rd = prdata;
			bad = pslverr;
			@(posedge pclk);
			k++;
		end while (ok !== 1'b1 && k < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			err_count++;
			end_of_test;
		end
	endtask
	task automatic wait_idle;
		int k;
		k = 0;
		do begin
			apb(1'b0, `SPP_STATUS_OFFSET, 32'h0);
			k++;
		// idle with an empty transmit buffer, so the one idle cycle between queued bytes does not count
		end while (rd[2:1] !== 2'b01 && k < 1000);
		if (rd[2:1] !== 2'b01) begin
			err_count++;
			end_of_test;
		end
	endtask
	// counts ticks up to the next rising clock on the serial line
	task automatic rise(output int k);
		k = 0;
		while (sck_w === 1'b1 && k < 600) begin
			tick;
			k++;
		end
		while (sck_w !== 1'b1 && k < 600) begin
			tick;
			k++;
		end
		if (k >= 600) begin
			err_count++;
			end_of_test;
		end
	endtask
	function automatic logic [31:0] rev8(input logic [7:0] b);
		return {24'h0, b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
	endfunction
	// plays an external master, mode 0 msb first, slow enough for the synchronisers
	task automatic slave_byte(input logic [7:0] b, output logic [7:0] s);
		s = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			@(posedge pclk);
			ext_mosi <= b[i];
			repeat (6) @(posedge pclk);
			ext_sck <= 1'b1;
			s = {s[6:0], miso_w};
			repeat (6) @(posedge pclk);
			ext_sck <= 1'b0;
		end
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, bad, rd} = '0;
		{ext_sck, ext_mosi} = 2'b00;
		ext_sel = 1'b1;
		err_count = 0;
		n_compared = 0;
		reply = 8'ha5;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `SPP_CTRL_OFFSET, 32'h0);
		check("ctrl reset", rd, 32'h0);
		apb(1'b0, `SPP_BAUD_OFFSET, 32'h0);
		check("baud reset", rd, 32'h0);
		apb(1'b1, 12'h010, 32'hff);
		check("unmapped err", {31'h0, bad}, 32'h1);
		// byte written while off is dropped, so enabling must not start a transfer
		apb(1'b1, `SPP_DATA_OFFSET, 32'h5a);
		check("pins off", {28'h0, sck_oe, mosi_oe, miso_oe, sel_oe}, 32'h0);
		apb(1'b1, `SPP_CTRL_OFFSET, 32'h63);
		apb(1'b0, `SPP_STATUS_OFFSET, 32'h0);
		check("status idle", rd, 32'h2);
		for (int p = 0; p < 8; p++) begin
			apb(1'b1, `SPP_BAUD_OFFSET, {25'h0, 3'(p), 1'b0, 3'(7 - p)});
			apb(1'b1, `SPP_DATA_OFFSET, 32'h3c);
			rise(n);
			rise(n);
			check("bit period", 32'(n), 32'((p + 1) * (2 ** (8 - p))));
			wait_idle;
		end
		apb(1'b0, `SPP_STATUS_OFFSET, 32'h0);
		check("status full", rd, 32'h3);
		apb(1'b0, `SPP_DATA_OFFSET, 32'h0);
		check("rx msb", rd, 32'ha5);
		check("far rx msb", {24'h0, got}, 32'h3c);
		// back-to-back, lsb first: second byte must wait behind the first
		apb(1'b1, `SPP_CTRL_OFFSET, 32'h67);
		reply = 8'hc4;
		apb(1'b1, `SPP_DATA_OFFSET, 32'h1e);
		apb(1'b1, `SPP_DATA_OFFSET, 32'h96);
		apb(1'b0, `SPP_STATUS_OFFSET, 32'h0);
		check("tx waiting", {31'h0, rd[1]}, 32'h0);
		wait_idle;
		check("far rx lsb", {24'h0, got}, rev8(8'h96));
		apb(1'b0, `SPP_DATA_OFFSET, 32'h0);
		check("rx lsb", rd, rev8(8'hc4));
		apb(1'b1, `SPP_DATA_OFFSET, 32'h55);
		repeat (20) tick;
		apb(1'b1, `SPP_CTRL_OFFSET, 32'h0);
		apb(1'b0, `SPP_STATUS_OFFSET, 32'h0);
		check("abort flags", rd, 32'h2);
		apb(1'b1, `SPP_CTRL_OFFSET, 32'h1b);
		repeat (4) tick;
		check("one wire out", {30'h0, mosi_oe, miso_oe}, 32'h2);
		apb(1'b1, `SPP_CTRL_OFFSET, 32'h0b);
		repeat (4) tick;
		check("one wire in", {30'h0, mosi_oe, miso_oe}, 32'h0);
		// unselected slave with a byte queued must stay silent
		apb(1'b1, `SPP_CTRL_OFFSET, 32'h01);
		apb(1'b1, `SPP_DATA_OFFSET, 32'h77);
		repeat (40) tick;
		check("slave pins", {29'h0, sck_oe, mosi_oe, miso_oe}, 32'h0);
		apb(1'b0, `SPP_STATUS_OFFSET, 32'h0);
		check("slave busy", {31'h0, rd[2]}, 32'h0);
		// selected slave: queued byte goes out on master-in, the clocked-in byte lands in the receive buffer
		ext_sel <= 1'b0;
		repeat (6) @(posedge pclk);
		slave_byte(8'hb2, sb);
		check("slave drives", {31'h0, miso_oe}, 32'h1);
		check("slave tx", {24'h0, sb}, 32'h77);
		repeat (6) @(posedge pclk);
		ext_sel <= 1'b1;
		apb(1'b0, `SPP_DATA_OFFSET, 32'h0);
		check("slave rx", rd, 32'hb2);
		end_of_test;
	end
endmodule

/* File: tb/spp_core_properties.sv */
// port-level assertions for the serial port core
`timescale 1ns/1ns
module spp_core_properties (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        serial_clock_pin_oe,
	input wire logic        mosi_pin_oe,
	input wire logic        miso_pin_oe,
	input wire logic        select_pin_in,
	input wire logic        select_pin_oe
);
	logic [6:0] ctrl_q;
	logic [1:0] calm;
	logic       m_on;
	logic       s_on;
	assign m_on = ctrl_q[0] & ctrl_q[1];
	assign s_on = ctrl_q[0] & ~ctrl_q[1];
	// shadow of the control word; pins lag it, so only judge once it has settled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 7'h00;
			calm   <= 2'h0;
		end else if (psel && penable && pready && pwrite && paddr == 12'h000) begin
			ctrl_q <= pwdata[6:0];
			calm   <= 2'h0;
		end else if (calm != 2'h3) begin
			calm <= calm + 2'h1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_bad_addr;
		s_setup ##0 (paddr > 12'h00c);
	endsequence
	AST_APB_READY: assert property (s_setup |=> pready) else $error("no ready in access cycle");
	AST_APB_UNMAPPED: assert property (s_bad_addr |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
	AST_OFF_RELEASE: assert property (calm == 2'h3 && !ctrl_q[0] |->
		!(serial_clock_pin_oe || mosi_pin_oe || miso_pin_oe || select_pin_oe)) else $error("pin driven while off");
	AST_MASTER_CLK: assert property (calm == 2'h3 && m_on |-> serial_clock_pin_oe)
		else $error("master clk off");
	AST_SLAVE_CLK_IN: assert property (calm == 2'h3 && s_on |->
		!serial_clock_pin_oe && !mosi_pin_oe) else $error("slave drives clk or mosi");
	AST_TWO_WIRE: assert property (calm == 2'h3 && m_on && !ctrl_q[3] |-> mosi_pin_oe && !miso_pin_oe)
		else $error("two-wire master routing");
	AST_ONE_WIRE: assert property (calm == 2'h3 && m_on && ctrl_q[3] |->
		!miso_pin_oe && mosi_pin_oe == ctrl_q[4]) else $error("single-wire master routing");
	AST_SLAVE_QUIET: assert property ((calm == 2'h3 && s_on && select_pin_in)[*5] |-> !miso_pin_oe)
		else $error("unselected slave drives");
	AST_SEL_FUNC: assert property (calm == 2'h3 |-> select_pin_oe == (m_on && ctrl_q[5] && ctrl_q[6]))
		else $error("select pin function");
endmodule
bind serial_peripheral_port_core spp_core_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .serial_clock_pin_oe, .mosi_pin_oe, .miso_pin_oe,
	.select_pin_in, .select_pin_oe);

/* File: tb/spp_slave_model.sv */
// far-side serial peripheral, mode 0, msb first
`timescale 1ns/1ns
module spp_slave_model (
	input wire logic       sck,
	input wire logic       sel_n,
	input wire logic       mosi,
	input wire logic [7:0] reply,
	output logic           miso,
	output logic [7:0]     got
);
	logic [7:0] sh;
	logic [7:0] rx;
	logic [2:0] cnt;
	initial begin
		sh = 8'h00;
		rx = 8'h00;
		cnt = 3'h0;
		miso = 1'b0;
		got = 8'h00;
	end
	// first bit must be on the line before the first clock edge
	always @(negedge sel_n) begin
		sh = reply;
		cnt = 3'h0;
		miso = reply[7];
	end
	// released line: show the inverse so a stale value never passes
	always @(posedge sel_n) miso = ~miso;
	always @(posedge sck) begin
		if (!sel_n) begin
			rx = {rx[6:0], mosi};
			cnt = cnt + 3'h1;
			// take the byte on the eighth rise: the last fall may meet the select release in one step
			if (cnt == 3'h0) begin
				got = rx;
			end
		end
	end
	always @(negedge sck) begin
		if (!sel_n) begin
			if (cnt == 3'h0) begin
				sh = reply;
			end else begin
				sh = sh << 1;
			end
			miso = sh[7];
		end
	end
endmodule
